// ===== design/hswl_params.svh
// Constants of the hot swap warning-limit and summary status bank.
// Assumes inclusion by the hswl_bank module of this bank only.
`ifndef HSWL_PARAMS_SVH
`define HSWL_PARAMS_SVH
// Command codes
`define HSWL_CMD_OUTPUT_ON 8'h01
`define HSWL_CMD_FAULT_CLEAR 8'h03
`define HSWL_CMD_VIN_OV_WARN 8'h57
`define HSWL_CMD_VIN_UV_WARN 8'h58
`define HSWL_CMD_PIN_WARN 8'h6B
`define HSWL_CMD_SUMMARY 8'h78
`define HSWL_CMD_CUR2_WARN 8'hD7
// Reset values
`define HSWL_RST_VIN_OV 12'hFFF
`define HSWL_RST_VIN_UV 12'h000
`define HSWL_RST_PIN 15'h7FFF
`define HSWL_RST_CUR2 12'h000
`define HSWL_RST_OUTPUT_ON 1'b1
// Field positions in the summary byte
`define HSWL_BIT_GATE_OFF 6
`define HSWL_BIT_OC_FAULT 4
`define HSWL_BIT_UV_FAULT 3
`define HSWL_BIT_COMM_ERR 1
`define HSWL_BIT_OTHER 0
// Position of the on bit in the output control byte
`define HSWL_BIT_OUTPUT_ON 7
`endif

// ===== design/hswl_pkg.sv
// Types of the hot swap warning-limit and summary status bank.
// Assumes the constants header is on the include path.
package hswl_pkg;
  // Transaction kinds seen by the bank
  typedef enum logic [2:0] {
    HSWL_IDLE = 3'b001,
    HSWL_WRITE = 3'b010,
    HSWL_READ = 3'b100
  } hswl_op_type;
endpackage

// ===== design/hswl_threshold_reg.sv
// One threshold register with reserved upper bits.
// Assumes writes arrive as single-cycle strobes with word data.
`timescale 1ns/1ns
module hswl_threshold_reg
  import hswl_pkg::*;
#(
  parameter int WIDTH = 12,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Write side
  input wire logic i_wr_en,
  input wire logic [15:0] i_wr_data,
  // Stored limit
  output logic [WIDTH-1:0] o_value
);
  typedef struct packed {
    logic [WIDTH-1:0] value;
  } hswl_thr_state_type;

  hswl_thr_state_type state_q;
  hswl_thr_state_type state_d;

  // =========================================
  // Next value: upper written bits are dropped, so reserved bits stay zero
  always_comb begin
    state_d = state_q;
    if (i_wr_en) begin
      state_d.value = i_wr_data[WIDTH-1:0];
    end
  end

  // Register
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q.value <= RESET_VALUE;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_value = state_q.value;
endmodule // hswl_threshold_reg

// ===== design/hswl_bank.sv
// Warning thresholds, output control and summary status of a hot swap monitor.
// Assumes a protocol engine that delivers decoded commands as one-cycle strobes
// synchronous to I_REF_CLK, and analog/fault inputs already synchronous.
`timescale 1ns/1ns
`include "hswl_params.svh"
module hswl_bank
  import hswl_pkg::*;
#(
  parameter int ADC_WIDTH = 12,
  parameter int POWER_WIDTH = 15
) (
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  // Decoded command port from the protocol engine
  input wire logic i_cmd_valid,
  input wire logic i_cmd_write,
  input wire logic i_cmd_send_byte,
  input wire logic [7:0] i_cmd_code,
  input wire logic [15:0] i_cmd_wdata,
  input wire logic i_comm_error,
  // Read answer
  output logic [15:0] o_rdata,
  output logic o_rdata_valid,
  output logic o_cmd_unsupported,
  // Measurements
  input wire logic [ADC_WIDTH-1:0] i_vin_code,
  input wire logic [ADC_WIDTH-1:0] i_iout_code,
  input wire logic [POWER_WIDTH-1:0] i_pin_code,
  input wire logic i_current_threshold_direction_select,
  // Fault and gate sources
  input wire logic i_overcurrent_shutdown_fault,
  input wire logic i_input_undervoltage_fault,
  input wire logic i_gate_drive_off,
  input wire logic i_other_status_pending,
  // Control and warning outputs
  output logic o_output_on_control,
  output logic o_vin_ov_warn,
  output logic o_vin_uv_warn,
  output logic o_pin_warn,
  output logic o_current2_warn,
  output logic o_fault_clear
);
  typedef struct packed {
    hswl_op_type op;
    logic [15:0] rdata;
    logic rdata_valid;
    logic unsupported;
    logic output_on;
    logic oc_fault;
    logic uv_fault;
    logic comm_err;
    logic clear;
    logic ov_warn;
    logic uv_warn;
    logic pin_warn;
    logic cur2_warn;
  } hswl_state_type;

  hswl_state_type state_q;
  hswl_state_type state_d;

  logic [ADC_WIDTH-1:0] vin_ov_q;
  logic [ADC_WIDTH-1:0] vin_uv_q;
  logic [ADC_WIDTH-1:0] cur2_q;
  logic [POWER_WIDTH-1:0] pin_q;
  logic wr_hit;
  logic [7:0] summary;

  // =========================================
  // Threshold registers
  assign wr_hit = i_cmd_valid && i_cmd_write && !i_cmd_send_byte;

  hswl_threshold_reg #(.WIDTH(ADC_WIDTH), .RESET_VALUE(`HSWL_RST_VIN_OV)) u_vin_ov (
    .i_clk(I_REF_CLK),
    .i_reset(I_RESET),
    .i_wr_en(wr_hit && (i_cmd_code == `HSWL_CMD_VIN_OV_WARN)),
    .i_wr_data(i_cmd_wdata),
    .o_value(vin_ov_q)
  );
  hswl_threshold_reg #(.WIDTH(ADC_WIDTH), .RESET_VALUE(`HSWL_RST_VIN_UV)) u_vin_uv (
    .i_clk(I_REF_CLK),
    .i_reset(I_RESET),
    .i_wr_en(wr_hit && (i_cmd_code == `HSWL_CMD_VIN_UV_WARN)),
    .i_wr_data(i_cmd_wdata),
    .o_value(vin_uv_q)
  );
  hswl_threshold_reg #(.WIDTH(POWER_WIDTH), .RESET_VALUE(`HSWL_RST_PIN)) u_pin (
    .i_clk(I_REF_CLK),
    .i_reset(I_RESET),
    .i_wr_en(wr_hit && (i_cmd_code == `HSWL_CMD_PIN_WARN)),
    .i_wr_data(i_cmd_wdata),
    .o_value(pin_q)
  );
  hswl_threshold_reg #(.WIDTH(ADC_WIDTH), .RESET_VALUE(`HSWL_RST_CUR2)) u_cur2 (
    .i_clk(I_REF_CLK),
    .i_reset(I_RESET),
    .i_wr_en(wr_hit && (i_cmd_code == `HSWL_CMD_CUR2_WARN)),
    .i_wr_data(i_cmd_wdata),
    .o_value(cur2_q)
  );

  // =========================================
  // Summary byte; reserved bits 7, 5, 2 stay zero
  always_comb begin
    summary = 8'h00;
    summary[`HSWL_BIT_GATE_OFF] = i_gate_drive_off;
    summary[`HSWL_BIT_OC_FAULT] = state_q.oc_fault;
    summary[`HSWL_BIT_UV_FAULT] = state_q.uv_fault;
    summary[`HSWL_BIT_COMM_ERR] = state_q.comm_err;
    summary[`HSWL_BIT_OTHER] = i_other_status_pending;
  end

  // =========================================
  // Next state: decode, latches, comparisons
  always_comb begin
    state_d = state_q;
    state_d.rdata_valid = 1'b0;
    state_d.unsupported = 1'b0;
    state_d.clear = 1'b0;
    state_d.op = HSWL_IDLE;
    if (i_cmd_valid) begin
      state_d.op = i_cmd_write ? HSWL_WRITE : HSWL_READ;
    end
    if (i_cmd_valid && i_cmd_send_byte) begin
      if (i_cmd_code == `HSWL_CMD_FAULT_CLEAR) begin
        state_d.clear = 1'b1;
        state_d.oc_fault = 1'b0;
        state_d.uv_fault = 1'b0;
        state_d.comm_err = 1'b0;
      end else begin
        state_d.unsupported = 1'b1;
      end
    end else if (i_cmd_valid) begin
      unique case (i_cmd_code)
        `HSWL_CMD_OUTPUT_ON: begin
          if (i_cmd_write) begin
            state_d.output_on = i_cmd_wdata[`HSWL_BIT_OUTPUT_ON];
          end else begin
            state_d.rdata = {8'h00, state_q.output_on, 7'h00};
          end
        end
        `HSWL_CMD_VIN_OV_WARN: state_d.rdata = 16'(vin_ov_q);
        `HSWL_CMD_VIN_UV_WARN: state_d.rdata = 16'(vin_uv_q);
        `HSWL_CMD_PIN_WARN: state_d.rdata = 16'(pin_q);
        `HSWL_CMD_CUR2_WARN: state_d.rdata = 16'(cur2_q);
        `HSWL_CMD_SUMMARY: begin
          state_d.rdata = {8'h00, summary};
          state_d.unsupported = i_cmd_write;
        end
        default: state_d.unsupported = 1'b1;
      endcase
      state_d.rdata_valid = !i_cmd_write;
    end
    if (i_overcurrent_shutdown_fault) begin
      state_d.oc_fault = 1'b1;
    end
    if (i_input_undervoltage_fault) begin
      state_d.uv_fault = 1'b1;
    end
    if (i_comm_error || state_d.unsupported) begin
      state_d.comm_err = 1'b1;
    end
    state_d.ov_warn = i_vin_code > vin_ov_q;
    state_d.uv_warn = i_vin_code < vin_uv_q;
    state_d.pin_warn = i_pin_code > pin_q;
    state_d.cur2_warn = i_current_threshold_direction_select ?
      (i_iout_code < cur2_q) : (i_iout_code > cur2_q);
  end

  // Register the state
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      state_q <= '0;
      state_q.op <= HSWL_IDLE;
      state_q.output_on <= `HSWL_RST_OUTPUT_ON;
    end else begin
      state_q <= state_d;
    end
  end

  // =========================================
  // Outputs
  assign o_rdata = state_q.rdata;
  assign o_rdata_valid = state_q.rdata_valid;
  assign o_cmd_unsupported = state_q.unsupported;
  assign o_output_on_control = state_q.output_on;
  assign o_vin_ov_warn = state_q.ov_warn;
  assign o_vin_uv_warn = state_q.uv_warn;
  assign o_pin_warn = state_q.pin_warn;
  assign o_current2_warn = state_q.cur2_warn;
  assign o_fault_clear = state_q.clear;
endmodule // hswl_bank

// ===== testbench/hswl_bank_monitor.sv
// Checker of the bank's answers and summary status byte.
// Assumes a bind onto hswl_bank; one clock, async active-high reset.
`timescale 1ns/1ns
module hswl_bank_monitor (
  // Clock, reset and command
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  input wire logic i_cmd_valid,
  input wire logic i_cmd_write,
  input wire logic i_cmd_send_byte,
  input wire logic [7:0] i_cmd_code,
  input wire logic i_comm_error,
  // Answers and sources
  input wire logic [15:0] o_rdata,
  input wire logic o_rdata_valid,
  input wire logic o_cmd_unsupported,
  input wire logic o_fault_clear,
  input wire logic i_overcurrent_shutdown_fault,
  input wire logic i_input_undervoltage_fault,
  input wire logic i_gate_drive_off,
  input wire logic i_other_status_pending
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RESET);
  // ==========
  // Request kinds; quiet means no fault or comm error input is active
  logic rd, rd_st, quiet;
  assign rd = i_cmd_valid && !i_cmd_write && !i_cmd_send_byte;
  assign rd_st = rd && i_cmd_code == 8'h78;
  assign quiet = !i_overcurrent_shutdown_fault && !i_input_undervoltage_fault && !i_comm_error;
  AST_PAD12: assert property (rd && i_cmd_code inside {8'h57, 8'h58, 8'hd7} |=>
    o_rdata_valid && o_rdata[15:12] == 4'h0) else $error("threshold pad bits set");
  AST_PWR_TOP: assert property (rd && i_cmd_code == 8'h6b |=> !o_rdata[15])
    else $error("power threshold top bit set");
  AST_ST_RSV: assert property (rd_st |=> o_rdata_valid && (o_rdata & 16'hffa4) == 16'h0000)
    else $error("status reserved bits set");
  AST_ST_RO: assert property (i_cmd_valid && i_cmd_write && i_cmd_code == 8'h78 |=> o_cmd_unsupported)
    else $error("status write not refused");
  AST_CLEAR: assert property (i_cmd_valid && i_cmd_send_byte && i_cmd_code == 8'h03 |=>
    o_fault_clear && !o_cmd_unsupported) else $error("fault clear not taken");
  AST_LIVE: assert property (rd_st |=> o_rdata[6] == $past(i_gate_drive_off) &&
    o_rdata[0] == $past(i_other_status_pending)) else $error("live status bits wrong");
  AST_OC_LATCH: assert property (i_overcurrent_shutdown_fault ##1 rd_st |=> o_rdata[4])
    else $error("overcurrent bit not latched");
  AST_CLEARED: assert property (quiet ##1 (o_fault_clear && quiet && rd_st) |=>
    (o_rdata & 16'h001a) == 16'h0000) else $error("latched bits survive clear");
  // Main scenarios reached
  cover property (o_fault_clear);
  cover property (o_cmd_unsupported);
  cover property (rd_st ##1 o_rdata[4]);
endmodule // hswl_bank_monitor

// ===== testbench/hswl_host_model.sv
// Host side model issuing decoded one-cycle commands.
// Assumes the bench calls cmd from a falling edge after reset.
`timescale 1ns/1ns
module hswl_host_model (
  input wire logic i_clk,
  output logic o_valid,
  output logic o_write,
  output logic o_send_byte,
  output logic [7:0] o_code,
  output logic [15:0] o_wdata
);
  initial {o_valid, o_write, o_send_byte, o_code, o_wdata} = '0;
  // send byte carries no data
  // Valid stays up between back-to-back commands, so no signal is driven twice in one step
  task automatic cmd(input logic wr, input logic sb, input logic [7:0] cd, input logic [15:0] dt);
    o_valid = 1'b1;
    o_write = wr;
    o_send_byte = sb;
    o_code = cd;
    o_wdata = sb ? ~o_wdata : dt;
    @(negedge i_clk);
  endtask
  // Drops valid once the last command of a burst has been taken
  task automatic idle();
    o_valid = 1'b0;
    o_wdata = ~o_wdata; // Idle data never repeats the last word
  endtask
endmodule // hswl_host_model

// ===== testbench/tb.sv
// Bench of the warning-limit bank with host model and checker.
// Assumes design files, host model and checker compile first.
`timescale 1ns/1ns
module tb;
  import hswl_pkg::*;
  logic I_REF_CLK = 1'b0;
  logic I_RESET = 1'b1;
  logic i_cmd_valid, i_cmd_write, i_cmd_send_byte;
  logic [7:0] i_cmd_code;
  logic [15:0] i_cmd_wdata, o_rdata, r = 16'h0009;
  logic i_comm_error = '0, i_current_threshold_direction_select = '0;
  logic i_overcurrent_shutdown_fault = '0, i_input_undervoltage_fault = '0;
  logic i_gate_drive_off = '0, i_other_status_pending = '0;
  logic [11:0] i_vin_code = '0, i_iout_code = '0;
  logic [14:0] i_pin_code = '0;
  logic o_rdata_valid, o_cmd_unsupported, o_output_on_control, o_fault_clear;
  logic o_vin_ov_warn, o_vin_uv_warn, o_pin_warn, o_current2_warn;
  logic [15:0] q[$];
  logic [7:0] cd[4] = '{8'h57, 8'h58, 8'hd7, 8'h6b};
  logic [15:0] mk[4] = '{16'h0fff, 16'h0fff, 16'h0fff, 16'h7fff};
  int errors = 0, num_checks = 0;
  always #5 I_REF_CLK = ~I_REF_CLK;
  hswl_host_model u_hswl_host_model (.i_clk(I_REF_CLK), .o_valid(i_cmd_valid),
    .o_write(i_cmd_write), .o_send_byte(i_cmd_send_byte), .o_code(i_cmd_code),
    .o_wdata(i_cmd_wdata));
  hswl_bank u_hswl_bank (.*);
  // ==========
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    q.push_back(e);
    u_hswl_host_model.cmd(1'b0, 1'b0, c, 16'h0000);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    u_hswl_host_model.cmd(1'b1, 1'b0, c, d);
  endtask
  // Outstanding reads must land before a reset or the end
  task automatic drain();
    u_hswl_host_model.idle();
    for (int t = 0; t < 20 && q.size() > 0; t++) @(negedge I_REF_CLK);
    if (q.size() > 0) begin
      chk(16'(q.size()), 16'h0000);
      stop_test();
    end
  endtask
  // Each answer takes the oldest note, looked at mid-cycle while it stands
  always @(negedge I_REF_CLK) begin
    if (o_rdata_valid === 1'b1) begin
      if (q.size() > 0) chk(o_rdata, q.pop_front());
      else chk(16'h0001, 16'h0000);
    end
  end
  initial begin
    repeat (10) @(negedge I_REF_CLK);
    I_RESET = 1'b0;
    @(negedge I_REF_CLK);
    // Reset values, then random back-to-back write and readback
    for (int i = 0; i < 4; i++) rd(cd[i], mk[i] == 16'h7fff ? mk[i] : mk[i] & {16{i == 0}});
    rd(8'h01, 16'h0080);
    for (int i = 0; i < 12; i++) begin
      r = lfsr(r);
      wr(cd[i % 4], r);
      rd(cd[i % 4], r & mk[i % 4]);
    end
    // Strict comparisons either side of one threshold, both directions
    for (int i = 0; i < 4; i++) wr(cd[i], 16'h0100);
    u_hswl_host_model.idle();
    for (int j = 0; j < 6; j++) begin
      i_vin_code = 12'h0ff + 12'(j % 3);
      i_iout_code = i_vin_code;
      i_pin_code = {3'h0, i_vin_code};
      i_current_threshold_direction_select = 1'(j / 3);
      repeat (2) @(negedge I_REF_CLK);
      chk(16'(o_vin_ov_warn), 16'(j % 3 == 2));
      chk(16'(o_vin_uv_warn), 16'(j % 3 == 0));
      chk(16'(o_pin_warn), 16'(j % 3 == 2));
      chk(16'(o_current2_warn), 16'(j / 3 ? j % 3 == 0 : j % 3 == 2));
    end
    // Latched faults, refusal, live bits, then clear
    {i_overcurrent_shutdown_fault, i_input_undervoltage_fault} = 2'h3;
    {i_gate_drive_off, i_other_status_pending} = 2'h3;
    @(negedge I_REF_CLK);
    {i_overcurrent_shutdown_fault, i_input_undervoltage_fault} = 2'h0;
    rd(8'h78, 16'h0059);
    wr(8'h78, 16'hffff);
    chk(16'(o_cmd_unsupported), 16'h0001);
    rd(8'h78, 16'h005b);
    {i_gate_drive_off, i_other_status_pending} = 2'h0;
    u_hswl_host_model.cmd(1'b0, 1'b1, 8'h03, 16'h0000);
    chk(16'(o_fault_clear), 16'h0001);
    rd(8'h78, 16'h0000);
    u_hswl_host_model.idle();
    i_comm_error = 1'b1;
    @(negedge I_REF_CLK);
    i_comm_error = 1'b0;
    rd(8'h78, 16'h0002);
    // Send byte with an unknown code is refused
    u_hswl_host_model.cmd(1'b0, 1'b1, 8'h00, 16'h0000);
    chk(16'(o_cmd_unsupported), 16'h0001);
    // Output off, then a mid-run reset restores defaults
    wr(8'h01, 16'h0000);
    chk(16'(o_output_on_control), 16'h0000);
    rd(8'h01, 16'h0000);
    drain();
    I_RESET = 1'b1;
    repeat (2) @(negedge I_REF_CLK);
    I_RESET = 1'b0;
    @(negedge I_REF_CLK);
    chk(16'(o_output_on_control), 16'h0001);
    rd(8'h57, 16'h0fff);
    rd(8'h78, 16'h0000);
    drain();
    stop_test();
  end
endmodule // tb
bind hswl_bank hswl_bank_monitor u_hswl_bank_monitor (.*);
